// *** hw/sadc_pkg.sv ***
// Shared constants and types for the sampling converter parallel interface.
//==========================================================================
//==========================================================================
package sadc_pkg;
  localparam int DATA_W = 12;
  localparam int CLK_MHZ = 20;
  localparam int CONV_NS = 1600;
  localparam int ACQ_NS = 250;
  localparam int WAKE_NS = 350;
  // Least times round up to whole cycles.
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 6;
  localparam int FIFO_DEPTH = 8;
  localparam logic [DATA_W-1:0] RESULT_RST = 12'h000;
  localparam logic [DATA_W-1:0] BIPOLAR_FLIP = 12'h800;
  typedef enum logic [1:0] {
    SADC_MODE_ALWAYS,
    SADC_MODE_STROBED,
    SADC_MODE_SLOWMEM,
    SADC_MODE_ROM
  } sadc_mode_t;
  typedef enum logic [1:0] {
    SADC_ST_OFF,
    SADC_ST_WAKE,
    SADC_ST_IDLE,
    SADC_ST_CONV
  } sadc_state_t;
endpackage

// *** hw/sadc_if.sv ***
// Parallel bus between converter and host, with three-state data lanes.
`timescale 1ns/1ps
interface sadc_if;
  import sadc_pkg::*;
  logic cs_n;
  logic rd_n;
  logic convert_start_n;
  logic power_down_n;
  logic busy_n_high;
  logic [DATA_W-1:0] data_o;
  logic data_oe_n;
  logic [DATA_W-1:0] data;
  // Data lanes float (all ones as pull-up) when the converter is not driving.
  assign data = data_oe_n ? {DATA_W{1'b1}} : data_o;
  modport dev (
    input cs_n, rd_n, convert_start_n, power_down_n,
    output busy_n_high, data_o, data_oe_n
  );
  modport host (
    output cs_n, rd_n, convert_start_n, power_down_n,
    input busy_n_high, data
  );
endinterface

// *** hw/sadc_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage is written without reset; only pointers and the count need a defined value.
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap on the power-of-two depth.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** hw/sadc_dev.sv ***
// Converter end: start decode, self-timed conversion, shutdown and data drive.
`timescale 1ns/1ps
module sadc_dev (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link to the host.
  sadc_if.dev bus,
  // Sampled analog value and coding select.
  input wire logic [sadc_pkg::DATA_W-1:0] sample_code,
  input wire logic bipolar
);
  import sadc_pkg::*;
  sadc_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic cs_rd_start_n_q;
  logic start_fall;
  logic [DATA_W-1:0] sample_q;
  logic [DATA_W-1:0] result_q;

  //==========================================================================
  // Start detection
  //==========================================================================
  // Only the falling edge of convert start counts, so a held-low start in
  // slow memory or ROM mode does not retrigger after completion.
  assign start_fall = !bus.convert_start_n && cs_rd_start_n_q && !bus.cs_n;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_rd_start_n_q <= 1'b1;
    end
    else
    begin
      cs_rd_start_n_q <= bus.convert_start_n;
    end
  end

  //==========================================================================
  // Conversion sequencer
  //==========================================================================
  // Shutdown overrides everything; wake-up delay blocks starts for one OFF cycle plus WAKE_CYC cycles (400 ns).
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= SADC_ST_IDLE;
      cnt_q <= '0;
    end
    else if (!bus.power_down_n)
    begin
      state_q <= SADC_ST_OFF;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        SADC_ST_OFF:
        begin
          state_q <= SADC_ST_WAKE;
          cnt_q <= CNT_W'(WAKE_CYC - 1);
        end
        SADC_ST_WAKE:
        begin
          if (cnt_q == '0)
          begin
            state_q <= SADC_ST_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        SADC_ST_IDLE:
        begin
          if (start_fall)
          begin
            state_q <= SADC_ST_CONV;
            cnt_q <= CNT_W'(CONV_CYC - 1);
          end
        end
        SADC_ST_CONV:
        begin
          // Further starts are not looked at until the count ends.
          if (cnt_q == '0)
          begin
            state_q <= SADC_ST_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  //==========================================================================
  // Sample and result
  //==========================================================================
  // The input is held at the start; the result replaces the old one only
  // as the conversion ends, so reads during conversion see the old value.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sample_q <= RESULT_RST;
      result_q <= RESULT_RST;
    end
    else
    begin
      if (state_q == SADC_ST_IDLE && start_fall && bus.power_down_n)
      begin
        sample_q <= sample_code;
      end
      if (state_q == SADC_ST_CONV && cnt_q == '0 && bus.power_down_n)
      begin
        // Bipolar input is offset binary internally; flip MSB for two's complement.
        result_q <= bipolar ? (sample_q ^ BIPOLAR_FLIP) : sample_q;
      end
    end
  end

  //==========================================================================
  // Outputs
  //==========================================================================
  assign bus.busy_n_high = (state_q != SADC_ST_CONV);
  assign bus.data_o = result_q;
  // Read-strobed drive; with both tied low the lanes stay driven.
  assign bus.data_oe_n = bus.cs_n || bus.rd_n;
endmodule

// *** hw/sadc_host.sv ***
// Host end: runs one of four access modes and streams results into a FIFO.
`timescale 1ns/1ps
module sadc_host (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link to the converter.
  sadc_if.host bus,
  // User controls.
  input wire sadc_pkg::sadc_mode_t mode,
  input wire logic run,
  input wire logic sleep,
  // Result stream.
  output logic res_valid,
  input wire logic res_ready,
  output logic [sadc_pkg::DATA_W-1:0] res_data
);
  import sadc_pkg::*;
  typedef enum logic [2:0] {
    SADC_H_SLEEP,
    SADC_H_WAKE,
    SADC_H_IDLE,
    SADC_H_START,
    SADC_H_WAIT,
    SADC_H_READ,
    SADC_H_GAP
  } sadc_hstate_t;
  sadc_hstate_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic busy_q;
  logic push;
  logic fifo_ready;
  logic [DATA_W-1:0] cap_q;
  logic cap_v_q;

  //==========================================================================
  // Result buffer
  //==========================================================================
  sadc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(cap_v_q),
    .in_ready(fifo_ready),
    .in_data(cap_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  //==========================================================================
  // Access sequencer
  //==========================================================================
  // A new start waits for free FIFO room, so back-pressure stalls sampling.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= SADC_H_SLEEP;
      cnt_q <= '0;
      busy_q <= 1'b1;
    end
    else
    begin
      busy_q <= bus.busy_n_high;
      unique case (st_q)
        SADC_H_SLEEP:
        begin
          if (!sleep)
          begin
            st_q <= SADC_H_WAKE;
            cnt_q <= CNT_W'(WAKE_CYC);
          end
        end
        SADC_H_WAKE:
        begin
          if (cnt_q == '0)
          begin
            st_q <= SADC_H_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        SADC_H_IDLE:
        begin
          if (sleep)
          begin
            st_q <= SADC_H_SLEEP;
          end
          else if (run && fifo_ready && !cap_v_q)
          begin
            st_q <= SADC_H_START;
          end
        end
        SADC_H_START:
        begin
          st_q <= SADC_H_WAIT;
        end
        SADC_H_WAIT:
        begin
          // Busy rising edge marks fresh data.
          if (bus.busy_n_high && !busy_q)
          begin
            st_q <= SADC_H_READ;
          end
        end
        SADC_H_READ:
        begin
          st_q <= SADC_H_GAP;
          cnt_q <= CNT_W'(ACQ_CYC);
        end
        SADC_H_GAP:
        begin
          // Hold off for the acquisition time before the next start.
          if (cnt_q == '0)
          begin
            st_q <= SADC_H_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        // The eighth code is unused; fall back to a clean shutdown.
        default:
        begin
          st_q <= SADC_H_SLEEP;
        end
      endcase
    end
  end

  //==========================================================================
  // Pin drive
  //==========================================================================
  // Joined modes hold read and start low from start through the read cycle that follows busy rising.
  always_comb
  begin
    bus.power_down_n = (st_q != SADC_H_SLEEP);
    bus.cs_n = 1'b0;
    bus.convert_start_n = 1'b1;
    bus.rd_n = 1'b1;
    unique case (mode)
      SADC_MODE_ALWAYS:
      begin
        bus.rd_n = 1'b0;
        bus.convert_start_n = (st_q != SADC_H_START);
      end
      SADC_MODE_STROBED:
      begin
        bus.convert_start_n = (st_q != SADC_H_START);
        bus.rd_n = (st_q != SADC_H_READ);
      end
      SADC_MODE_SLOWMEM, SADC_MODE_ROM:
      begin
        // The joined strobe stays low through the read, so the lanes are still
        // driven at the edge that captures the new word.
        bus.convert_start_n = !(st_q inside {SADC_H_START, SADC_H_WAIT, SADC_H_READ});
        bus.rd_n = bus.convert_start_n;
      end
    endcase
  end

  //==========================================================================
  // Capture
  //==========================================================================
  // Slow memory reads the new word at busy rise; ROM keeps the fresh result
  // for the next strobe, so its capture here is of the word on the lanes
  // after completion, which is the new result.
  assign push = cap_v_q && fifo_ready;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_q <= RESULT_RST;
      cap_v_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        cap_v_q <= 1'b0;
      end
      if (st_q == SADC_H_READ)
      begin
        cap_q <= bus.data;
        cap_v_q <= 1'b1;
      end
    end
  end
endmodule

// *** testbench/sadc_monitor.sv ***
// Assertion checker watching the converter/host parallel link.
`timescale 1ns/1ps
module sadc_monitor (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link signals.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic convert_start_n,
  input wire logic power_down_n,
  input wire logic busy_n_high,
  input wire logic [sadc_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe_n
);
  import sadc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [5:0] busy_cnt_q;
  logic [3:0] wake_cnt_q;
  //==========================================================================
  // Helper counters
  // Cycles spent converting, cleared whenever busy is high.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_cnt_q <= 6'h00;
    else
      busy_cnt_q <= busy_n_high ? 6'h00 : busy_cnt_q + 6'h01;
  end
  // Cycles awake, saturating so a long run never wraps back into the wake window.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wake_cnt_q <= 4'h0;
    else if (!power_down_n)
      wake_cnt_q <= 4'h0;
    else if (wake_cnt_q != 4'hF)
      wake_cnt_q <= wake_cnt_q + 4'h1;
  end
  //==========================================================================
  // Properties
  // A start is owed once the wake count has passed its full span.
  a_start_busy_low: assert property ($fell(convert_start_n) && !cs_n
    && power_down_n && busy_n_high && wake_cnt_q > 4'(WAKE_CYC) |=> !busy_n_high)
    else $error("start not taken");
  a_busy_len_exact: assert property ($rose(busy_n_high) && power_down_n
    && $past(power_down_n) |-> busy_cnt_q == 6'(CONV_CYC)) else $error("busy length wrong");
  a_off_no_busy: assert property (!power_down_n |=> busy_n_high)
    else $error("conversion while shut down");
  a_idle_stays: assert property (busy_n_high && !($fell(convert_start_n) && !cs_n)
    |=> busy_n_high) else $error("busy without a start");
  a_data_at_done: assert property ($changed(data_o) |-> $rose(busy_n_high))
    else $error("result changed away from completion");
  // Lanes drive exactly while select and read are both low, and float otherwise.
  a_read_drives: assert property (data_oe_n == (cs_n || rd_n))
    else $error("lane drive does not follow read");
  a_host_wake_wait: assert property ($fell(convert_start_n)
    |-> power_down_n && wake_cnt_q >= 4'(WAKE_CYC)) else $error("start too soon after wake");
  a_acq_gap_kept: assert property ($rose(busy_n_high)
    |=> (!$fell(convert_start_n)) [*5]) else $error("acquisition gap too short");
endmodule

// *** testbench/sampling_adc_parallel_control_tb.sv ***
// Self-checking bench for the converter and host ends of the parallel link.
`timescale 1ns/1ps
module sampling_adc_parallel_control_tb;
  import sadc_pkg::*;
  logic core_clk, rst, run, sleep, res_ready, res_valid, bipolar, bip_b, bip_q, busy_q, pd_q;
  logic [DATA_W-1:0] sample_code, code_b, res_data, pend, code_q, exp_w;
  logic [DATA_W-1:0] corner[4] = '{12'h000, 12'hFFF, 12'h800, 12'h5A3};
  logic [DATA_W-1:0] expq[$];
  sadc_mode_t mode;
  int error_cnt, num_checks, n, pops;
  sadc_if bus ();
  sadc_if bus_b ();
  sadc_dev i_sadc_dev (.core_clk(core_clk), .rst(rst), .bus(bus), .sample_code(sample_code),
    .bipolar(bipolar));
  sadc_host i_sadc_host (.core_clk(core_clk), .rst(rst), .bus(bus), .mode(mode), .run(run),
    .sleep(sleep), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  // The second converter is driven by the bench so that host faults can be staged.
  sadc_dev i_sadc_dev_b (.core_clk(core_clk), .rst(rst), .bus(bus_b), .sample_code(code_b),
    .bipolar(bip_b));
  sadc_monitor i_sadc_monitor (.core_clk(core_clk), .rst(rst), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .convert_start_n(bus.convert_start_n), .power_down_n(bus.power_down_n),
    .busy_n_high(bus.busy_n_high), .data_o(bus.data_o), .data_oe_n(bus.data_oe_n));
  //==========================================================================
  // Helpers
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Two's complement is the offset code with its top bit flipped.
  function automatic logic [DATA_W-1:0] exp_code(logic [DATA_W-1:0] code, logic bip);
    return code ^ (bip ? BIPOLAR_FLIP : 12'h000);
  endfunction
  // One cycle low on the start line, entered right after an edge.
  task automatic start_b();
    bus_b.convert_start_n <= 1'b0;
    step(1);
    bus_b.convert_start_n <= 1'b1;
  endtask
  task automatic results();
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Words are sampled on the start edge and owed once a conversion completes unaborted.
  always @(posedge core_clk)
  begin
    if (rst)
      expq.delete();
    else
    begin
      if (bus.busy_n_high === 1'b0 && busy_q === 1'b1)
        pend <= exp_code(code_q, bip_q);
      if (bus.busy_n_high === 1'b1 && busy_q === 1'b0 && bus.power_down_n && pd_q)
        expq.push_back(pend);
      if (res_valid === 1'b1 && res_ready)
      begin
        pops++;
        // An unowed word is a mismatch of its own, so an unknown word cannot slip by.
        chk("word owed", 12'h001, {11'h000, expq.size() != 0});
        if (expq.size() != 0)
          chk("word", expq.pop_front(), res_data);
      end
    end
    busy_q <= bus.busy_n_high;
    pd_q <= bus.power_down_n;
    code_q <= sample_code;
    bip_q <= bipolar;
  end
  // A hang costs a mismatch; the span is several times the planned run.
  initial
  begin
    step(20000);
    error_cnt++;
    results();
  end
  //==========================================================================
  // Scenarios
  initial
  begin
    void'($urandom(32'hA7CE));
    {rst, run, sleep, res_ready, bipolar, bip_b, error_cnt, num_checks, pops} = '0;
    rst = 1'b1;
    mode = SADC_MODE_ALWAYS;
    sample_code = 12'h000;
    code_b = 12'h000;
    corner[3] = DATA_W'($urandom);
    {bus_b.cs_n, bus_b.rd_n, bus_b.convert_start_n, bus_b.power_down_n} = 4'h7;
    step(6);
    rst <= 1'b0;
    step(12);
    #1 chk("float", 12'hFFF, bus_b.data);
    step(1);
    bus_b.rd_n <= 1'b0;
    step(1);
    #1 chk("reset word", RESULT_RST, bus_b.data);
    exp_w = RESULT_RST;
    // Corner codes in alternating codings (unipolar, bipolar, unipolar, bipolar), with a stray start in mid-conversion.
    foreach (corner[i])
    begin
      step(3);
      code_b <= corner[i];
      bip_b <= i[0];
      start_b();
      #1 chk("busy", 12'h000, {11'h000, bus_b.busy_n_high});
      n = 0;
      do
      begin
        step(1);
        bus_b.convert_start_n <= (n != 9);
        #1 n++;
        if (n == 20) chk("old word", exp_w, bus_b.data);
      end while (bus_b.busy_n_high !== 1'b1 && n < 99);
      exp_w = exp_code(corner[i], i[0]);
      chk("conv time", 12'(CONV_CYC), 12'(n));
      chk("new word", exp_w, bus_b.data);
    end
    // Starts are refused asleep and while waking, and shutdown aborts a conversion.
    step(1);
    bus_b.power_down_n <= 1'b0;
    step(2);
    start_b();
    #1 chk("busy asleep", 12'h001, {11'h000, bus_b.busy_n_high});
    step(1);
    bus_b.power_down_n <= 1'b1;
    step(2);
    start_b();
    #1 chk("busy waking", 12'h001, {11'h000, bus_b.busy_n_high});
    step(12);
    start_b();
    #1 chk("busy awake", 12'h000, {11'h000, bus_b.busy_n_high});
    step(5);
    bus_b.power_down_n <= 1'b0;
    step(2);
    #1 chk("busy abort", 12'h001, {11'h000, bus_b.busy_n_high});
    chk("abort word", exp_w, bus_b.data);
    // Every access mode streams random words; the result side stalls until the FIFO refuses.
    for (int m = 0; m < 4; m++)
    begin
      step(1);
      mode <= sadc_mode_t'(m);
      bipolar <= m[0];
      run <= 1'b1;
      for (int k = 0; k < 1000; k++)
      begin
        step(1);
        sample_code <= DATA_W'($urandom);
        res_ready <= (k > 450) && ($urandom_range(3) != 0);
      end
      // Let the last ready value take effect before it is changed again.
      step(1);
      run <= 1'b0;
      res_ready <= 1'b1;
      step(150);
      sleep <= 1'b1;
      step(4);
      sleep <= 1'b0;
    end
    step(100);
    chk("left over", 12'h000, 12'(expq.size()));
    chk("words seen", 12'h001, {11'h000, pops > 40});
    results();
  end
endmodule
